//--- design/lcf_pkg.sv
// package: coil function codes, relay map, counter/flasher widths and reset values
package lcf_pkg;

  // number of relay slots handled by the evaluator
  localparam int NUM_RELAYS   = 40;
  localparam int RELAY_IDX_W  = 6;
  // relay group bases: outputs 0..7, flags 8..23, text/expansion 24..31, jumps 32..39
  localparam logic [5:0] BASE_OUTPUT = 6'h00;
  localparam logic [5:0] BASE_FLAG   = 6'h08;
  localparam logic [5:0] BASE_TEXT   = 6'h18;
  localparam logic [5:0] BASE_JUMP   = 6'h20;
  localparam int CNT_OUTPUT   = 8;
  localparam int CNT_FLAG     = 16;
  localparam int CNT_TEXT     = 8;

  // function relays
  localparam int NUM_COUNTERS = 4;
  localparam int NUM_FLASHERS = 4;
  localparam int COUNT_W      = 16;
  localparam int TIME_W       = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] TIME_RESET  = 16'h0000;

  // coil function encoding, one-hot
  typedef enum logic [6:0] {
    LCF_FN_ENERGIZE = 7'h01,
    LCF_FN_NEGATE   = 7'h02,
    LCF_FN_FALL     = 7'h04,
    LCF_FN_RISE     = 7'h08,
    LCF_FN_TOGGLE   = 7'h10,
    LCF_FN_SET      = 7'h20,
    LCF_FN_RESET    = 7'h40
  } lcf_fn_t;

  // one coil evaluation handed over by the program walker
  typedef struct packed {
    logic                   valid;
    lcf_fn_t                fn;
    logic [RELAY_IDX_W-1:0] relay;
    logic                   coilIn;
  } lcf_coil_t;

  // scan control
  typedef struct packed {
    logic runMode;
    logic powerFail;
    logic scanStart;
    logic scanEnd;
  } lcf_scan_t;

  // scan sequencer states
  typedef enum logic [2:0] {
    LCF_ST_STOP = 3'h1,
    LCF_ST_PASS = 3'h2,
    LCF_ST_FUNC = 3'h4
  } lcf_state_t;

endpackage

//--- design/lcf_relay_mem.sv
// relay memory: per-relay state and previous coil input, registered read
module lcf_relay_mem
  import lcf_pkg::*;
#(
  parameter int N  = NUM_RELAYS,
  parameter int AW = RELAY_IDX_W
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clear,
  input  wire logic [N-1:0]  keepMask,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic          wrState,
  input  wire logic          wrPrev,
  input  wire logic [AW-1:0] rdAddr,
  output logic               rdState,
  output logic               rdPrev,
  output logic [N-1:0]       allState
);

  logic [N-1:0] state_q;
  logic [N-1:0] prev_q;

  // one slot per relay; clear spares retentive slots that are on
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gSlot
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          state_q[g] <= 1'b0;
          prev_q[g]  <= 1'b0;
        end else if (clear) begin
          state_q[g] <= state_q[g] & keepMask[g];
          prev_q[g]  <= 1'b0;
        end else if (wrEn && wrAddr == AW'(g)) begin
          state_q[g] <= wrState;
          prev_q[g]  <= wrPrev;
        end
      end
    end
  endgenerate

  // read port is registered so the walker sees a stable value
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdState <= 1'b0;
      rdPrev  <= 1'b0;
    end else begin
      rdState <= state_q[rdAddr];
      rdPrev  <= prev_q[rdAddr];
    end
  end

  assign allState = state_q;

endmodule

//--- design/lcf_coil_eval.sv
// coil function evaluator: relay coils per scan, counters and flashers after each pass
module lcf_coil_eval
  import lcf_pkg::*;
#(
  parameter int NR = NUM_RELAYS,
  parameter int NC = NUM_COUNTERS,
  parameter int NF = NUM_FLASHERS,
  parameter int CW = COUNT_W,
  parameter int TW = TIME_W
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire lcf_scan_t            scan,
  input  wire lcf_coil_t            coil,
  input  wire logic [NR-1:0]        retainMask,
  input  wire logic [NC-1:0]        cntUp,
  input  wire logic [NC-1:0]        cntDown,
  input  wire logic [NC-1:0]        cntClear,
  input  wire logic [NC*CW-1:0]     cntSetpoint,
  input  wire logic [NC-1:0]        cntRetain,
  input  wire logic [NF-1:0]        flashTrig,
  input  wire logic [NF*TW-1:0]     flashPause,
  input  wire logic [NF*TW-1:0]     flashPulse,
  output logic [NR-1:0]             relayState,
  output logic [NC-1:0]             cntContact,
  output logic [NF-1:0]             flashContact,
  output logic                      passDone
);

  lcf_state_t state_q, state_d;
  logic       coilValid_q;
  lcf_fn_t    coilFn_q;
  logic [RELAY_IDX_W-1:0] coilRelay_q;
  logic       coilIn_q;
  logic       rdState, rdPrev;
  logic [NR-1:0] allState;

  // latch capability check, used for write gating and the checks below
  function automatic logic canLatch(input logic [RELAY_IDX_W-1:0] r);
    canLatch = (r < RELAY_IDX_W'(BASE_TEXT + CNT_TEXT));
  endfunction

  // sequencer: stop clears, pass walks coils, func updates function relays
  wire stopNow   = !scan.runMode || scan.powerFail;
  wire passEnd   = (state_q == LCF_ST_PASS) && scan.scanEnd;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LCF_ST_STOP: if (!stopNow) state_d = LCF_ST_PASS;
      LCF_ST_PASS: if (stopNow) state_d = LCF_ST_STOP; else if (scan.scanEnd) state_d = LCF_ST_FUNC;
      LCF_ST_FUNC: state_d = stopNow ? LCF_ST_STOP : LCF_ST_PASS;
      default:     state_d = LCF_ST_STOP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) state_q <= LCF_ST_STOP;
    else          state_q <= state_d;
  end

  // coil request is registered so it lines up with the registered memory read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coilValid_q <= 1'b0;
      coilFn_q    <= LCF_FN_ENERGIZE;
      coilRelay_q <= '0;
      coilIn_q    <= 1'b0;
    end else begin
      coilValid_q <= coil.valid && (state_q == LCF_ST_PASS) && !stopNow;
      coilFn_q    <= coil.fn;
      coilRelay_q <= coil.relay;
      coilIn_q    <= coil.coilIn;
    end
  end

  // coil function decode; later coils simply overwrite, giving program order priority
  wire risingIn  = coilIn_q && !rdPrev;
  wire fallingIn = !coilIn_q && rdPrev;
  logic newState;
  always_comb begin
    newState = rdState;
    unique case (coilFn_q)
      LCF_FN_ENERGIZE: newState = coilIn_q;
      LCF_FN_NEGATE:   newState = !coilIn_q;
      LCF_FN_FALL:     newState = fallingIn;
      LCF_FN_RISE:     newState = risingIn;
      LCF_FN_TOGGLE:   newState = rdState ^ risingIn;
      LCF_FN_SET:      newState = rdState | coilIn_q;
      LCF_FN_RESET:    newState = rdState & !coilIn_q;
      default:         newState = rdState;
    endcase
  end
  wire latchFn = (coilFn_q == LCF_FN_SET) || (coilFn_q == LCF_FN_RESET);
  wire wrEn    = coilValid_q && !stopNow && (!latchFn || canLatch(coilRelay_q));

  // back-to-back coils on the same relay would read stale data; the walker spaces them
  lcf_relay_mem #(.N(NR), .AW(RELAY_IDX_W)) uMem (
    .clk      (clk),
    .reset_n  (reset_n),
    .clear    (stopNow),
    .keepMask (retainMask),
    .wrEn     (wrEn),
    .wrAddr   (coilRelay_q),
    .wrState  (newState),
    .wrPrev   (coilIn_q),
    .rdAddr   (coil.relay),
    .rdState  (rdState),
    .rdPrev   (rdPrev),
    .allState (allState)
  );

  wire funcStep = (state_q == LCF_ST_FUNC) && !stopNow;

  // counters: count on coil edges once per pass, contact at or above setpoint
  logic [NC-1:0] upPrev_q, dnPrev_q;
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : gCnt
      logic [CW-1:0] count_q;
      wire [CW-1:0] setp = cntSetpoint[c*CW +: CW];
      wire upEdge = cntUp[c] && !upPrev_q[c];
      wire dnEdge = cntDown[c] && !dnPrev_q[c];
      // contact is judged on the count this step leaves; it lags only after a stop, which clears it while cntRetain keeps the count
      wire [CW-1:0] nextCnt = cntClear[c]          ? CW'(COUNT_RESET) :
                              (upEdge && !dnEdge)  ? count_q + CW'(1) :
                              (dnEdge && !upEdge)  ? count_q - CW'(1) :
                              count_q;
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          count_q     <= COUNT_RESET;
          upPrev_q[c] <= 1'b0;
          dnPrev_q[c] <= 1'b0;
          cntContact[c] <= 1'b0;
        end else if (stopNow) begin
          if (!cntRetain[c]) count_q <= COUNT_RESET;
          upPrev_q[c] <= 1'b0;
          dnPrev_q[c] <= 1'b0;
          cntContact[c] <= 1'b0;
        end else if (funcStep) begin
          count_q     <= nextCnt;
          upPrev_q[c] <= cntUp[c];
          dnPrev_q[c] <= cntDown[c];
          cntContact[c] <= (nextCnt >= setp);
        end
      end
      cnt_contact_a: assert property (@(posedge clk) disable iff (!reset_n)
        funcStep && !stopNow |=> cntContact[c] == (count_q >= setp)) else $error("counter contact wrong");
    end
  endgenerate

  // flashers: count passes; pause for setpoint one, then pulse for setpoint two
  genvar f;
  generate
    for (f = 0; f < NF; f++) begin : gFl
      logic [TW-1:0] tick_q;
      logic          inPulse_q;
      wire [TW-1:0] pauseT = flashPause[f*TW +: TW];
      wire [TW-1:0] pulseT = flashPulse[f*TW +: TW];
      wire phaseDone = (tick_q + TW'(1)) >= (inPulse_q ? pulseT : pauseT);
      always_ff @(posedge clk) begin
        if (!reset_n || stopNow) begin
          tick_q    <= TIME_RESET;
          inPulse_q <= 1'b0;
          flashContact[f] <= 1'b0;
        end else if (funcStep) begin
          if (!flashTrig[f]) begin
            tick_q    <= TIME_RESET;
            inPulse_q <= 1'b0;
          end else if (phaseDone) begin
            tick_q    <= TIME_RESET;
            inPulse_q <= !inPulse_q;
          end else begin
            tick_q <= tick_q + TW'(1);
          end
          flashContact[f] <= flashTrig[f] && (phaseDone ? !inPulse_q : inPulse_q);
        end
      end
    end
  endgenerate

  // outputs come from flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      relayState <= '0;
      passDone   <= 1'b0;
    end else begin
      relayState <= allState;
      passDone   <= passEnd && !stopNow;
    end
  end

  sequence stopSeen_s; stopNow; endsequence
  sequence clearedAfter_s; ##2 (relayState & ~retainMask) == '0; endsequence
  stop_clears_a: assert property (@(posedge clk) disable iff (!reset_n)
    stopSeen_s ##1 stopNow |-> clearedAfter_s) else $error("stop did not clear coils");
  energize_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && coilFn_q == LCF_FN_ENERGIZE && !$past(stopNow) ##1 !stopNow |=> relayState[$past(coilRelay_q,2)] == $past(coilIn_q,2))
    else $error("energize state wrong");
  negate_inv_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && coilFn_q == LCF_FN_NEGATE |-> newState == !coilIn_q) else $error("negate wrong");
  toggle_flip_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && coilFn_q == LCF_FN_TOGGLE && coilIn_q && !rdPrev |-> newState != rdState) else $error("toggle missed");
  fall_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && coilFn_q == LCF_FN_FALL |-> newState == (rdPrev && !coilIn_q)) else $error("fall pulse wrong");
  rise_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && coilFn_q == LCF_FN_RISE |-> newState == (!rdPrev && coilIn_q)) else $error("rise pulse wrong");
  set_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && coilFn_q == LCF_FN_SET && coilIn_q |-> newState) else $error("set not latched");
  latch_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    wrEn && latchFn |-> canLatch(coilRelay_q)) else $error("latch outside range");
  pass_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    passDone |=> !passDone) else $error("pass end pulse too long");
  func_after_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    passEnd && !stopNow |=> state_q == LCF_ST_FUNC) else $error("function step skipped");

endmodule

//--- bench/lcf_prog_model.sv
// partner model: program walker handing coils and pass ends to the evaluator
module lcf_prog_model
  import lcf_pkg::*;
(
  input  wire logic clk,
  output lcf_coil_t coil,
  output lcf_scan_t scan
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus until the first request
  initial begin
    coil = '0;
    scan = '0;
  end

  // one coil per call; idle cycles after it keep one relay from coming back to back
  task automatic put(input lcf_fn_t fn, input logic [5:0] r, input logic v);
    @(posedge clk);
    #1 coil = '{valid: 1'b1, fn: fn, relay: r, coilIn: v};
    @(posedge clk);
    #1 coil.valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // one-cycle pulse closing a program pass
  task automatic pulse_end();
    @(posedge clk);
    #1 scan.scanEnd = 1'b1;
    @(posedge clk);
    #1 scan.scanEnd = 1'b0;
  endtask

  // run/stop and power state, given time to settle
  task automatic mode(input logic run, input logic pf);
    @(posedge clk);
    #1 scan.runMode = run;
    scan.powerFail = pf;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule

//--- bench/test_ladder_coil_function_evaluator.sv
// testbench: coil functions, latch priority, stop clearing, counter contact
module test_ladder_coil_function_evaluator
  import lcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                            clk = 1'b0;
  logic                            reset_n = 1'b0;
  lcf_coil_t                       coil;
  lcf_scan_t                       scan;
  logic [NUM_RELAYS-1:0]           retainMask = 40'h00_0000_0008;
  logic [NUM_COUNTERS-1:0]         cntUp = 4'h0;
  logic [NUM_COUNTERS-1:0]         cntRetain = 4'h0;
  logic [NUM_COUNTERS*COUNT_W-1:0] cntSetpoint = 64'h0000_0000_0000_0002;
  logic [NUM_FLASHERS-1:0]         flashTrig = 4'h0;
  logic [NUM_FLASHERS*TIME_W-1:0]  flashPause = 64'h0000_0000_0000_0002;
  logic [NUM_FLASHERS*TIME_W-1:0]  flashPulse = 64'h0000_0000_0000_0001;
  logic [NUM_RELAYS-1:0]           relayState;
  logic [NUM_COUNTERS-1:0]         cntContact;
  logic [NUM_FLASHERS-1:0]         flashContact;
  logic                            passDone;
  int                              err_count = 0;
  int                              comparisons = 0;

  always #5 clk = ~clk;

  lcf_prog_model prog (.clk(clk), .coil(coil), .scan(scan));

  // counter down/clear inputs tied off: not reached by these scenarios
  lcf_coil_eval i_lcf_coil_eval (
    .clk(clk), .reset_n(reset_n), .scan(scan), .coil(coil), .retainMask(retainMask),
    .cntUp(cntUp), .cntDown(4'h0), .cntClear(4'h0), .cntSetpoint(cntSetpoint),
    .cntRetain(cntRetain), .flashTrig(flashTrig), .flashPause(flashPause), .flashPulse(flashPulse),
    .relayState(relayState), .cntContact(cntContact), .flashContact(flashContact),
    .passDone(passDone)
  );

  task automatic chk(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: expected %0h got %0h", $time, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // close a pass; passDone is awaited under a bound, then function step lands
  task automatic end_pass();
    int i;
    prog.pulse_end();
    for (i = 0; i < 4 && passDone !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (passDone !== 1'b1) begin
      err_count++;
      finish_test();
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_energize();
    prog.put(LCF_FN_ENERGIZE, 6'h00, 1'b1);
    chk(1'b1, relayState[0]);
    prog.put(LCF_FN_NEGATE, 6'h01, 1'b1);
    chk(1'b0, relayState[1]);
    prog.put(LCF_FN_NEGATE, 6'h01, 1'b0);
    chk(1'b1, relayState[1]);
    prog.put(LCF_FN_ENERGIZE, 6'h04, 1'b1);
    prog.put(LCF_FN_ENERGIZE, 6'h04, 1'b0);
    chk(1'b0, relayState[4]);
  endtask

  // edge coils only on flag relays 8 and 9, as programs should do
  task automatic t_edges();
    prog.put(LCF_FN_FALL, 6'h08, 1'b1);
    prog.put(LCF_FN_RISE, 6'h09, 1'b0);
    end_pass();
    prog.put(LCF_FN_FALL, 6'h08, 1'b0);
    chk(1'b1, relayState[8]);
    prog.put(LCF_FN_RISE, 6'h09, 1'b1);
    chk(1'b1, relayState[9]);
    end_pass();
    prog.put(LCF_FN_FALL, 6'h08, 1'b0);
    chk(1'b0, relayState[8]);
    prog.put(LCF_FN_RISE, 6'h09, 1'b1);
    chk(1'b0, relayState[9]);
  endtask

  task automatic t_toggle();
    prog.put(LCF_FN_TOGGLE, 6'h0A, 1'b1);
    chk(1'b1, relayState[10]);
    end_pass();
    prog.put(LCF_FN_TOGGLE, 6'h0A, 1'b1);
    chk(1'b1, relayState[10]);
    end_pass();
    prog.put(LCF_FN_TOGGLE, 6'h0A, 1'b0);
    end_pass();
    prog.put(LCF_FN_TOGGLE, 6'h0A, 1'b1);
    chk(1'b0, relayState[10]);
  endtask

  task automatic t_latch();
    prog.put(LCF_FN_SET, 6'h03, 1'b1);
    prog.put(LCF_FN_SET, 6'h03, 1'b0);
    chk(1'b1, relayState[3]);
    prog.put(LCF_FN_SET, 6'h03, 1'b1);
    prog.put(LCF_FN_RESET, 6'h03, 1'b1);
    chk(1'b0, relayState[3]);
    prog.put(LCF_FN_RESET, 6'h03, 1'b1);
    prog.put(LCF_FN_SET, 6'h03, 1'b1);
    chk(1'b1, relayState[3]);
    prog.put(LCF_FN_SET, 6'h21, 1'b1);
    chk(1'b0, relayState[33]);
    prog.put(LCF_FN_SET, 6'h1F, 1'b1);
    chk(1'b1, relayState[31]);
  endtask

  // count rises once per pass; setpoint 2
  task automatic t_counter();
    cntUp = 4'h1;
    end_pass();
    chk(1'b0, cntContact[0]);
    cntUp = 4'h0;
    end_pass();
    cntUp = 4'h1;
    end_pass();
    chk(1'b1, cntContact[0]);
  endtask

  // flasher pause 2 passes, pulse 1 pass; steady cycle checked after the start-up phase
  task automatic t_flash();
    flashTrig = 4'h1;
    repeat (2) end_pass();
    end_pass();
    chk(1'b0, flashContact[0]);
    end_pass();
    chk(1'b0, flashContact[0]);
    end_pass();
    chk(1'b1, flashContact[0]);
    end_pass();
    chk(1'b0, flashContact[0]);
    flashTrig = 4'h0;
    end_pass();
    chk(1'b0, flashContact[0]);
  endtask

  // power loss: only retentive relay 3 keeps its on state
  task automatic t_stop();
    prog.mode(1'b0, 1'b1);
    chk(1'b1, relayState[3]);
    chk(1'b0, relayState[0]);
    chk(1'b0, relayState[31]);
    chk(1'b0, cntContact[0]);
    prog.mode(1'b1, 1'b0);
  endtask

  initial begin
    prog.mode(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    t_energize();
    t_edges();
    t_toggle();
    t_latch();
    t_counter();
    t_flash();
    t_stop();
    finish_test();
  end
endmodule
